// ===== verilog/bss_pkg.sv
`default_nettype none
package bss_pkg;

  // Primary source field codes
  localparam logic [3:0] FIELD_STRAPS = 4'h0;
  localparam logic [3:0] FIELD_FLASH = 4'h1;
  localparam logic [3:0] FIELD_SD0 = 4'h2;
  localparam logic [3:0] FIELD_SD1 = 4'h3;
  localparam logic [3:0] FIELD_SPI_TARGET = 4'h4;
  localparam logic [3:0] FIELD_UART = 4'h6;
  localparam logic [3:0] FIELD_SPI_NOR = 4'h7;
  localparam logic [3:0] FIELD_USB_HID = 4'h8;
  localparam logic [3:0] FIELD_FUSE_ISP = 4'h9;
  localparam logic [3:0] FIELD_FLASH_REC = 4'hc;
  localparam logic [3:0] FIELD_SD0_REC = 4'hd;
  localparam logic [3:0] FIELD_SD1_REC = 4'he;

  // Strap codes, order {pin2, pin1, pin0}
  localparam logic [2:0] STRAP_USB_HID = 3'h2;
  localparam logic [2:0] STRAP_FLASH = 3'h3;
  localparam logic [2:0] STRAP_SD0 = 3'h4;
  localparam logic [2:0] STRAP_SERIAL_ISP = 3'h6;
  localparam logic [2:0] STRAP_SERIAL_DL = 3'h7;

  // Fuse word holding the instance selects
  localparam logic [7:0] SELECT_FUSE_WORD = 8'h60;
  localparam int FUSE_WORD_WIDTH = 32;
  localparam int SERIAL_SEL_LSB = 17;
  localparam int SERIAL_SEL_MSB = 19;
  localparam int ISP_SEL_LSB = 4;
  localparam int ISP_SEL_MSB = 6;

  // Reset values
  localparam logic [3:0] FIELD_RESET = 4'h0;
  localparam logic [2:0] STRAP_RESET = 3'h0;
  localparam logic [2:0] SEL_RESET = 3'h0;

  typedef enum logic [3:0] {
    BSS_PATH_NONE = 4'h0,
    BSS_PATH_FLASH = 4'h1,
    BSS_PATH_SD0 = 4'h2,
    BSS_PATH_SD1 = 4'h3,
    BSS_PATH_SPI_TARGET = 4'h4,
    BSS_PATH_UART = 4'h5,
    BSS_PATH_SPI_NOR = 4'h6,
    BSS_PATH_USB_HID = 4'h7,
    BSS_PATH_FUSE_ISP = 4'h8,
    BSS_PATH_SERIAL_ISP = 4'h9,
    BSS_PATH_SERIAL_DL = 4'ha,
    BSS_PATH_RESERVED = 4'hf
  } bss_path_t;

  typedef enum logic [1:0] {
    BSS_ST_FUSE = 2'b00,
    BSS_ST_STRAP = 2'b01,
    BSS_ST_DECODE = 2'b10,
    BSS_ST_DONE = 2'b11
  } bss_state_t;

endpackage
`default_nettype wire

// ===== verilog/bss_decode.sv
`timescale 1ns/1ps
`default_nettype none
module bss_decode (
  input wire logic [3:0] field_in,
  input wire logic [2:0] strap_in,
  output bss_pkg::bss_path_t path_out,
  output logic has_recovery_out,
  output logic reserved_out
);

  always_comb begin
    path_out = bss_pkg::BSS_PATH_RESERVED;
    has_recovery_out = 1'b0;
    reserved_out = 1'b0;
    unique case (field_in)
      bss_pkg::FIELD_STRAPS: begin
        unique case (strap_in)
          bss_pkg::STRAP_USB_HID: path_out = bss_pkg::BSS_PATH_USB_HID;
          bss_pkg::STRAP_FLASH: path_out = bss_pkg::BSS_PATH_FLASH;
          bss_pkg::STRAP_SD0: path_out = bss_pkg::BSS_PATH_SD0;
          bss_pkg::STRAP_SERIAL_ISP: path_out = bss_pkg::BSS_PATH_SERIAL_ISP;
          bss_pkg::STRAP_SERIAL_DL: path_out = bss_pkg::BSS_PATH_SERIAL_DL;
          default: reserved_out = 1'b1;
        endcase
      end
      bss_pkg::FIELD_FLASH: path_out = bss_pkg::BSS_PATH_FLASH;
      bss_pkg::FIELD_SD0: path_out = bss_pkg::BSS_PATH_SD0;
      bss_pkg::FIELD_SD1: path_out = bss_pkg::BSS_PATH_SD1;
      bss_pkg::FIELD_SPI_TARGET: path_out = bss_pkg::BSS_PATH_SPI_TARGET;
      bss_pkg::FIELD_UART: path_out = bss_pkg::BSS_PATH_UART;
      bss_pkg::FIELD_SPI_NOR: path_out = bss_pkg::BSS_PATH_SPI_NOR;
      bss_pkg::FIELD_USB_HID: path_out = bss_pkg::BSS_PATH_USB_HID;
      bss_pkg::FIELD_FUSE_ISP: path_out = bss_pkg::BSS_PATH_FUSE_ISP;
      bss_pkg::FIELD_FLASH_REC: begin
        path_out = bss_pkg::BSS_PATH_FLASH;
        has_recovery_out = 1'b1;
      end
      bss_pkg::FIELD_SD0_REC: begin
        path_out = bss_pkg::BSS_PATH_SD0;
        has_recovery_out = 1'b1;
      end
      bss_pkg::FIELD_SD1_REC: begin
        path_out = bss_pkg::BSS_PATH_SD1;
        has_recovery_out = 1'b1;
      end
      // Reserved codes boot nowhere rather than guess a path
      default: reserved_out = 1'b1;
    endcase
  end

endmodule // bss_decode
`default_nettype wire

// ===== verilog/bss_boot_select.sv
// What this block does
// - Read fuse field first after reset
// - Unprogrammed field: sample three strap pins
// - Field 0000 selects strap pin decoding
// - 0001 boots SPI flash controller 0
// - 0010/0011 boot SD on port 0/1
// - 0100 downloads image over SPI target
// - 0110 downloads image over UART
// - 0111 single-bit NOR, instance fuse bits 19:17
// - 1000 USB-HID download into SRAM
// - 1001 programming mode, peripheral fuse bits 6:4
// - 1100 flash, then SPI-flash recovery
// - 1101/1110 SD port, then SPI-flash recovery
// - Strap codes decode to five boot paths
`timescale 1ns/1ps
`default_nettype none
module bss_boot_select #(
  parameter int FUSE_WIDTH = bss_pkg::FUSE_WORD_WIDTH
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic [3:0] primary_source_field_in,
  input wire logic [FUSE_WIDTH-1:0] select_fuse_word_in,
  input wire logic strap_pin0_in,
  input wire logic strap_pin1_in,
  input wire logic strap_pin2_in,
  input wire logic primary_no_image_in,
  output bss_pkg::bss_path_t boot_path_out,
  output logic boot_ready_out,
  output logic has_recovery_out,
  output logic recovery_active_out,
  output logic reserved_out,
  output logic field_unprogrammed_out,
  output logic [2:0] serial_instance_out,
  output logic [2:0] isp_periph_out
);

  bss_pkg::bss_state_t state_ff;
  bss_pkg::bss_state_t nxt_state;
  logic [3:0] field_ff;
  logic [2:0] strap_ff;
  logic [2:0] serial_sel_ff;
  logic [2:0] isp_sel_ff;
  bss_pkg::bss_path_t path_ff;
  logic ready_ff;
  logic recov_ff;
  logic reserved_ff;
  logic active_ff;
  bss_pkg::bss_path_t dec_path;
  logic dec_recov;
  logic dec_reserved;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      bss_pkg::BSS_ST_FUSE: begin
        if (primary_source_field_in == bss_pkg::FIELD_STRAPS) begin
          nxt_state = bss_pkg::BSS_ST_STRAP;
        end else begin
          nxt_state = bss_pkg::BSS_ST_DECODE;
        end
      end
      bss_pkg::BSS_ST_STRAP: nxt_state = bss_pkg::BSS_ST_DECODE;
      bss_pkg::BSS_ST_DECODE: nxt_state = bss_pkg::BSS_ST_DONE;
      bss_pkg::BSS_ST_DONE: nxt_state = bss_pkg::BSS_ST_DONE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      state_ff <= bss_pkg::BSS_ST_FUSE;
    end else if (clk_en_in) begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture, once per reset

  // Fuses are read before the straps are even looked at
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      field_ff <= bss_pkg::FIELD_RESET;
      serial_sel_ff <= bss_pkg::SEL_RESET;
      isp_sel_ff <= bss_pkg::SEL_RESET;
    end else if (clk_en_in && state_ff == bss_pkg::BSS_ST_FUSE) begin
      field_ff <= primary_source_field_in;
      serial_sel_ff <= select_fuse_word_in[bss_pkg::SERIAL_SEL_MSB:bss_pkg::SERIAL_SEL_LSB];
      isp_sel_ff <= select_fuse_word_in[bss_pkg::ISP_SEL_MSB:bss_pkg::ISP_SEL_LSB];
    end
  end

  // Straps only matter when the field is blank
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      strap_ff <= bss_pkg::STRAP_RESET;
    end else if (clk_en_in && state_ff == bss_pkg::BSS_ST_STRAP) begin
      strap_ff <= {strap_pin2_in, strap_pin1_in, strap_pin0_in};
    end
  end

  bss_decode u_decode (
    .field_in(field_ff),
    .strap_in(strap_ff),
    .path_out(dec_path),
    .has_recovery_out(dec_recov),
    .reserved_out(dec_reserved)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Result

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      path_ff <= bss_pkg::BSS_PATH_NONE;
      recov_ff <= 1'b0;
      reserved_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else if (clk_en_in && state_ff == bss_pkg::BSS_ST_DECODE) begin
      path_ff <= dec_path;
      recov_ff <= dec_recov;
      reserved_ff <= dec_reserved;
      ready_ff <= 1'b1;
    end
  end

  // Sticky until reset; the primary path is kept for reporting
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      active_ff <= 1'b0;
    end else if (clk_en_in && ready_ff && recov_ff && primary_no_image_in) begin
      active_ff <= 1'b1;
    end
  end

  assign boot_path_out = path_ff;
  assign boot_ready_out = ready_ff;
  assign has_recovery_out = recov_ff;
  assign recovery_active_out = active_ff;
  assign reserved_out = reserved_ff;
  assign field_unprogrammed_out = ready_ff && (field_ff == bss_pkg::FIELD_STRAPS);
  assign serial_instance_out = serial_sel_ff;
  assign isp_periph_out = isp_sel_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  fuse_first_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (state_ff == bss_pkg::BSS_ST_FUSE && clk_en_in) |=>
      field_ff == $past(primary_source_field_in) && state_ff != bss_pkg::BSS_ST_DONE)
    else $error("fuse field not captured first");

  strap_entry_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (state_ff == bss_pkg::BSS_ST_FUSE && clk_en_in && primary_source_field_in == 4'h0) |=>
      state_ff == bss_pkg::BSS_ST_STRAP)
    else $error("blank field did not go to straps");

  strap_skip_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (state_ff == bss_pkg::BSS_ST_FUSE && clk_en_in && primary_source_field_in != 4'h0) |=>
      state_ff == bss_pkg::BSS_ST_DECODE)
    else $error("programmed field sampled straps");

  flash_path_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    ($rose(ready_ff) && field_ff == 4'h1) |->
      path_ff == bss_pkg::BSS_PATH_FLASH && !recov_ff)
    else $error("flash field decoded wrong");

  sd_port_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    ($rose(ready_ff) && field_ff == 4'h3) |-> path_ff == bss_pkg::BSS_PATH_SD1)
    else $error("sd port 1 decoded wrong");

  target_dl_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    ($rose(ready_ff) && field_ff == 4'h4) |-> path_ff == bss_pkg::BSS_PATH_SPI_TARGET)
    else $error("spi target decoded wrong");

  uart_dl_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    ($rose(ready_ff) && field_ff == 4'h6) |-> path_ff == bss_pkg::BSS_PATH_UART)
    else $error("uart decoded wrong");

  nor_inst_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (state_ff == bss_pkg::BSS_ST_FUSE && clk_en_in) |=> ##2
      serial_instance_out == $past(select_fuse_word_in[19:17], 3))
    else $error("serial instance not from fuse bits");

  usb_dl_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    ($rose(ready_ff) && field_ff == 4'h8) |-> path_ff == bss_pkg::BSS_PATH_USB_HID)
    else $error("usb field decoded wrong");

  isp_sel_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    ($rose(ready_ff) && field_ff == 4'h9) |-> path_ff == bss_pkg::BSS_PATH_FUSE_ISP)
    else $error("fuse isp decoded wrong");

  isp_bits_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (state_ff == bss_pkg::BSS_ST_FUSE && clk_en_in) |=>
      isp_periph_out == $past(select_fuse_word_in[6:4]))
    else $error("isp peripheral not from fuse bits");

  flash_rec_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    ($rose(ready_ff) && field_ff == 4'hc) |->
      path_ff == bss_pkg::BSS_PATH_FLASH && recov_ff)
    else $error("flash recovery decoded wrong");

  sd_rec_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (ready_ff && recov_ff && primary_no_image_in && clk_en_in) |=> recovery_active_out)
    else $error("recovery not entered");

  strap_usb_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    ($rose(ready_ff) && field_ff == 4'h0 && strap_ff == 3'h2) |->
      path_ff == bss_pkg::BSS_PATH_USB_HID)
    else $error("strap usb decoded wrong");

  hold_result_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $past(ready_ff) |-> ready_ff && $stable(path_ff) && $stable(field_ff) && $stable(strap_ff))
    else $error("boot result changed after decode");

  fuse_boot_c: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    $rose(ready_ff) && field_ff != 4'h0);
  strap_boot_c: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    $rose(ready_ff) && field_ff == 4'h0 && !reserved_ff);
  recovery_c: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    $rose(active_ff));
  reserved_c: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    $rose(ready_ff) && reserved_ff);

endmodule // bss_boot_select
`default_nettype wire

// ===== tb/bss_fuse_model.sv
`timescale 1ns/1ps
`default_nettype none
module bss_fuse_model (
  input wire logic [3:0] field_set_in,
  input wire logic [31:0] word_set_in,
  input wire logic [2:0] strap_set_in,
  input wire logic scramble_in,
  output logic [3:0] field_out,
  output logic [31:0] word_out,
  output logic strap_pin0_out,
  output logic strap_pin1_out,
  output logic strap_pin2_out
);
  ////////////////////////////////////////////////////////////
  // Scramble flips every level after capture, so a late resample shows
  assign field_out = scramble_in ? ~field_set_in : field_set_in;
  assign word_out = scramble_in ? ~word_set_in : word_set_in;
  assign {strap_pin2_out, strap_pin1_out, strap_pin0_out} = strap_set_in ^ {3{scramble_in}};
endmodule // bss_fuse_model
`default_nettype wire

// ===== tb/boot_source_select_test.sv
`timescale 1ns/1ps
`default_nettype none
module boot_source_select_test;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic clk_en_in = 1'b0;
  logic primary_no_image_in = 1'b0;
  logic [3:0] field_set = 4'h0;
  logic [31:0] word_set = 32'h0;
  logic [2:0] strap_set = 3'h0;
  logic scramble = 1'b0;
  logic [3:0] field_w;
  logic [31:0] word_w;
  logic pin0_w, pin1_w, pin2_w;
  bss_pkg::bss_path_t boot_path_out;
  logic boot_ready_out, has_recovery_out, recovery_active_out, reserved_out, field_unprogrammed_out;
  logic [2:0] serial_instance_out, isp_periph_out;
  int mismatches = 0;
  int num_checks = 0;

  ////////////////////////////////////////////////////////////
  initial forever #5 mclk_in = ~mclk_in;

  bss_fuse_model model (.field_set_in(field_set), .word_set_in(word_set), .strap_set_in(strap_set),
    .scramble_in(scramble), .field_out(field_w), .word_out(word_w), .strap_pin0_out(pin0_w),
    .strap_pin1_out(pin1_w), .strap_pin2_out(pin2_w));

  bss_boot_select uut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
    .primary_source_field_in(field_w), .select_fuse_word_in(word_w), .strap_pin0_in(pin0_w),
    .strap_pin1_in(pin1_w), .strap_pin2_in(pin2_w), .primary_no_image_in(primary_no_image_in),
    .boot_path_out(boot_path_out), .boot_ready_out(boot_ready_out), .has_recovery_out(has_recovery_out),
    .recovery_active_out(recovery_active_out), .reserved_out(reserved_out),
    .field_unprogrammed_out(field_unprogrammed_out), .serial_instance_out(serial_instance_out),
    .isp_periph_out(isp_periph_out));

  ////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic note(input logic bad, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (bad) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_path(input bss_pkg::bss_path_t got, input bss_pkg::bss_path_t exp);
    note(got !== exp, 32'(got), 32'(exp));
  endtask

  task automatic check_flag(input logic got, input logic exp);
    note(got !== exp, 32'(got), 32'(exp));
  endtask

  task automatic check_sel(input logic [2:0] got, input logic [2:0] exp);
    note(got !== exp, 32'(got), 32'(exp));
  endtask

  function automatic bss_pkg::bss_path_t exp_path(input logic [3:0] f, input logic [2:0] s);
    case (f)
      4'h0: case (s)
        3'h2: return bss_pkg::BSS_PATH_USB_HID;
        3'h3: return bss_pkg::BSS_PATH_FLASH;
        3'h4: return bss_pkg::BSS_PATH_SD0;
        3'h6: return bss_pkg::BSS_PATH_SERIAL_ISP;
        3'h7: return bss_pkg::BSS_PATH_SERIAL_DL;
        default: return bss_pkg::BSS_PATH_RESERVED;
      endcase
      4'h1, 4'hc: return bss_pkg::BSS_PATH_FLASH;
      4'h2, 4'hd: return bss_pkg::BSS_PATH_SD0;
      4'h3, 4'he: return bss_pkg::BSS_PATH_SD1;
      4'h4: return bss_pkg::BSS_PATH_SPI_TARGET;
      4'h6: return bss_pkg::BSS_PATH_UART;
      4'h7: return bss_pkg::BSS_PATH_SPI_NOR;
      4'h8: return bss_pkg::BSS_PATH_USB_HID;
      4'h9: return bss_pkg::BSS_PATH_FUSE_ISP;
      default: return bss_pkg::BSS_PATH_RESERVED;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////
  // One full decode per reset; stall holds clock enable low after release
  task automatic run_case(input logic [3:0] f, input logic [2:0] s, input int stall);
    logic [31:0] w;
    logic rec;
    int cnt;
    w = {12'h9a3, f[2:0] ^ s, 10'h155, f[2:0], 4'h6};
    rec = (f == 4'hc) || (f == 4'hd) || (f == 4'he);
    @(negedge mclk_in);
    reset_n_in = 1'b0;
    clk_en_in = 1'b0;
    scramble = 1'b0;
    field_set = f;
    word_set = w;
    strap_set = s;
    repeat (2) @(negedge mclk_in);
    check_flag(boot_ready_out, 1'b0);
    reset_n_in = 1'b1;
    repeat (stall) @(negedge mclk_in);
    check_flag(boot_ready_out, 1'b0);
    clk_en_in = 1'b1;
    // Early no-image report must be ignored before the decode lands
    primary_no_image_in = 1'b1;
    cnt = 0;
    // Limit of 7 keeps a hang visible in the 3-bit count compare
    while (boot_ready_out !== 1'b1 && cnt < 7) begin
      @(negedge mclk_in);
      cnt++;
    end
    primary_no_image_in = 1'b0;
    check_flag(recovery_active_out, 1'b0);
    check_sel(cnt[2:0], (f == 4'h0) ? 3'h3 : 3'h2);
    check_path(boot_path_out, exp_path(f, s));
    check_flag(reserved_out, exp_path(f, s) == bss_pkg::BSS_PATH_RESERVED);
    check_flag(has_recovery_out, rec);
    check_flag(field_unprogrammed_out, f == 4'h0);
    check_sel(serial_instance_out, w[19:17]);
    check_sel(isp_periph_out, w[6:4]);
    // Recovery only where the path owns one; inputs now disturbed
    scramble = 1'b1;
    primary_no_image_in = 1'b1;
    @(negedge mclk_in);
    primary_no_image_in = 1'b0;
    repeat (3) @(negedge mclk_in);
    check_flag(recovery_active_out, rec);
    check_path(boot_path_out, exp_path(f, s));
    check_sel(serial_instance_out, w[19:17]);
    check_flag(boot_ready_out, 1'b1);
  endtask

  initial begin
    repeat (6) @(negedge mclk_in);
    reset_n_in = 1'b1;
    for (int i = 1; i < 16; i++) run_case(i[3:0], 3'h5, 0);
    for (int i = 0; i < 8; i++) run_case(4'h0, i[2:0], i % 3);
    final_report();
  end

  // Whole run needs about 230 cycles; generous margin
  initial begin
    repeat (20000) @(posedge mclk_in);
    mismatches++;
    final_report();
  end
endmodule // boot_source_select_test
`default_nettype wire
